/* pkg/hfc_map.vh */
/*
  Constants for the NAND flash host sequencer: clock rate, pin timing,
  array geometry, address cycle layout, opcodes and request kinds.
  Assumes the includer works on a 25 MHz clock.
*/
`ifndef HFC_MAP_VH
`define HFC_MAP_VH

// Clock
`define HFC_CLK_NS 40

// Pin timing in ns
`define HFC_WE_LOW_NS 40
`define HFC_WE_HIGH_NS 40
`define HFC_SETUP_NS 40
`define HFC_RE_LOW_NS 120
`define HFC_RE_HIGH_NS 40
`define HFC_WB_NS 100

// Busy times in us (page_program_time, block_erase_time)
`define HFC_PROG_US 300
`define HFC_BERS_US 3000
`define HFC_TIMEOUT_MULT 4

// Geometry
`define HFC_PAGE_MAIN 2048
`define HFC_PAGE_SPARE 128
`define HFC_PAGE_BYTES 12'h880
`define HFC_PAGE_WORDS 11'h440
`define HFC_BLK_MAIN_KB 128
`define HFC_BLK_SPARE_KB 8
`define HFC_BLK_PAGES 64
`define HFC_BLOCKS 1024

// Address cycles and field positions
`define HFC_ADDR_CYCLES 2'h3
`define HFC_COL_MSB 11
`define HFC_PAGE_LSB 12
`define HFC_BLOCK_LSB 18
`define HFC_W_COL_MSB 10
`define HFC_W_PAGE_LSB 11

// Request kinds
`define HFC_K_CMD 3'h0
`define HFC_K_ADDR 3'h1
`define HFC_K_WR 3'h2
`define HFC_K_RD 3'h3
`define HFC_K_WAIT 3'h4

// Opcodes
`define HFC_OP_RESET 8'hFF
`define HFC_OP_STATUS 8'h70
`define HFC_OP_PROG 8'h80
`define HFC_OP_RAND_IN 8'h85
`define HFC_OP_REPROG 8'h8B
`define HFC_OP_PROG_GO 8'h10
`define HFC_OP_CACHE_GO 8'h15
`define HFC_OP_ERASE 8'h60
`define HFC_OP_ERASE_GO 8'hD0

// I/O output-enable masks: low byte only, all 16 lines
`define HFC_IO_LOW_OE 16'h00FF
`define HFC_IO_ALL_OE 16'hFFFF

`endif

/* rtl/hfc_buf2.v */
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes a single clock and that clkEn low freezes it.
*/
`timescale 1ns/1ns
module hfc_buf2 #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire clkEn,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem_q [0:1];
  reg wrPtr_q;
  reg rdPtr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;

  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q[0] <= {WIDTH{1'b0}};
      mem_q[1] <= {WIDTH{1'b0}};
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (clkEn) begin
      if (push) begin
        mem_q[wrPtr_q] <= inData;
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule

/* rtl/hfc_nand_host.v */
/*
  Host-side sequencer for an asynchronous NAND flash pin interface.
  Takes one request at a time (command, address, data write, data read,
  wait for ready) and turns it into strobe cycles on the pins.
  Assumes pin inputs are asynchronous to ref_clk; the board resolves the
  I/O lines from ioOut/ioOe and pulls the ready/busy line up.
*/
`timescale 1ns/1ns
`include "hfc_map.vh"

// Notes on behaviour
// R1 - Low ready/busy means device busy; wait
// R2 - Read strobe low pulses; host never drives then
// R3 - Chip select high while idle for standby
// R4 - Command latch high during write strobe pulse
// R5 - Address latch high during write strobe pulse
// R6 - Device latches on write strobe rising edge
// R7 - Write protect low blocks program and erase
// R8 - Low byte carries commands, addresses, data
// R9 - High byte only for x16 data words
// R10 - Page is 2048 plus 128 bytes
// R11 - Erase block is 128K plus 8K bytes
// R12 - 1024 blocks of 64 pages
// R13 - One word per read strobe, sequential
// R14 - After confirm, device works alone; just wait
// R15 - Four address cycles: column, page, block
// R16 - Command needs CE low, ALE low, RE high
// R17 - While busy only reset and status; strobes high
// R18 - Chip select high means strobes are ignored
module hfc_nand_host #(
  parameter BUSY_LIMIT =
    `HFC_BERS_US * 1000 / `HFC_CLK_NS * `HFC_TIMEOUT_MULT
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire clkEn,
  // Request port
  input wire opValid,
  output wire opReady,
  input wire [2:0] opKind,
  input wire [27:0] opData,
  // Mode and protection
  input wire wordMode,
  input wire allowWrite,
  // Read data port
  output wire rdValid,
  input wire rdReady,
  output wire [15:0] rdData,
  // Status
  output reg opError_q,
  output wire devBusy,
  // Flash pins
  output reg ceN_q,
  output reg cle_q,
  output reg ale_q,
  output reg weN_q,
  output reg read_strobe_n_q,
  output reg wpN_q,
  output reg [15:0] ioOut_q,
  output reg [15:0] ioOe_q,
  input wire [15:0] ioIn,
  input wire rbN
);

  ////////////////////////////////////////////////////////////////////////
  // States and timing counts

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_SETUP = 7'h02;
  localparam [6:0] S_WLO = 7'h04;
  localparam [6:0] S_WHI = 7'h08;
  localparam [6:0] S_RLO = 7'h10;
  localparam [6:0] S_RHI = 7'h20;
  localparam [6:0] S_WAIT = 7'h40;

  // Keeps the low 20 bits of a cycle count on purpose
  function [19:0] cut20;
    input integer n;
    reg [31:0] w;
    begin
      w = n;
      cut20 = w[19:0];
    end
  endfunction

  localparam [19:0] SETUP_CYC =
    cut20((`HFC_SETUP_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS);
  localparam [19:0] WLO_CYC =
    cut20((`HFC_WE_LOW_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS);
  localparam [19:0] WHI_CYC =
    cut20((`HFC_WE_HIGH_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS);
  localparam [19:0] RLO_CYC =
    cut20((`HFC_RE_LOW_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS);
  localparam [19:0] RHI_CYC =
    cut20((`HFC_RE_HIGH_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS);
  localparam [19:0] WB_CYC =
    cut20((`HFC_WB_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS);
  localparam [19:0] LIMIT_CYC = cut20(BUSY_LIMIT);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Opcodes that start or confirm array modification
  function isModify;
    input [7:0] op;
    begin
      isModify = (op == `HFC_OP_PROG) || (op == `HFC_OP_RAND_IN) ||
        (op == `HFC_OP_REPROG) || (op == `HFC_OP_PROG_GO) ||
        (op == `HFC_OP_CACHE_GO) || (op == `HFC_OP_ERASE) ||
        (op == `HFC_OP_ERASE_GO);
    end
  endfunction

  // Byte for address cycle idx
  function [7:0] addrByte;
    input [27:0] a;
    input [1:0] idx;
    input wide;
    begin
      case (idx)
        2'h0: addrByte = a[7:0];
        2'h1: addrByte = wide ? {5'h00, a[10:8]} :
          {4'h0, a[`HFC_COL_MSB:8]};
        2'h2: addrByte = wide ? a[18:`HFC_W_PAGE_LSB] :
          a[19:`HFC_PAGE_LSB];
        default: addrByte = wide ? a[26:19] : a[27:20]; // R11 R12
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg rbS1_q;
  reg rbS2_q;
  reg [15:0] ioS1_q;
  reg [15:0] ioS2_q;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rbS1_q <= 1'b1;
      rbS2_q <= 1'b1;
      ioS1_q <= 16'h0000;
      ioS2_q <= 16'h0000;
    end else if (clkEn) begin
      rbS1_q <= rbN;
      rbS2_q <= rbS1_q;
      ioS1_q <= ioIn;
      ioS2_q <= ioS1_q;
    end
  end

  assign devBusy = !rbS2_q; // R1

  ////////////////////////////////////////////////////////////////////////
  // Read buffer

  reg bufPush_q;
  reg [15:0] bufData_q;
  wire bufInReady;

  hfc_buf2 #(
    .WIDTH(16)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .inValid(bufPush_q),
    .inReady(bufInReady),
    .inData(bufData_q),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Request gating

  reg [6:0] state_q;
  reg [19:0] cnt_q;
  reg [2:0] kind_q;
  reg [27:0] data_q;
  reg [1:0] idx_q;
  wire isCmd;
  wire busyOk;
  wire colBad;
  wire wpBad;

  assign isCmd = (opKind == `HFC_K_CMD);
  assign busyOk = rbS2_q || (opKind == `HFC_K_WAIT) ||
    (isCmd && ((opData[7:0] == `HFC_OP_RESET) ||
    (opData[7:0] == `HFC_OP_STATUS))); // R17
  // Column beyond page end
  assign colBad = (opKind == `HFC_K_ADDR) && (wordMode ?
    (opData[`HFC_W_COL_MSB:0] >= `HFC_PAGE_WORDS) :
    (opData[`HFC_COL_MSB:0] >= `HFC_PAGE_BYTES)); // R10
  assign wpBad = isCmd && isModify(opData[7:0]) && !allowWrite; // R7
  // No read starts without buffer room, so no word is lost
  assign opReady = clkEn && (state_q == S_IDLE) && busyOk && !bufPush_q &&
    ((opKind != `HFC_K_RD) || bufInReady);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      cnt_q <= 20'h00000;
      kind_q <= `HFC_K_CMD;
      data_q <= 28'h0000000;
      idx_q <= 2'h0;
      ceN_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      weN_q <= 1'b1;
      read_strobe_n_q <= 1'b1;
      wpN_q <= 1'b0;
      ioOut_q <= 16'h0000;
      ioOe_q <= 16'h0000;
      opError_q <= 1'b0;
      bufPush_q <= 1'b0;
      bufData_q <= 16'h0000;
    end else if (clkEn) begin
      opError_q <= 1'b0;
      bufPush_q <= 1'b0;
      wpN_q <= allowWrite; // R7
      case (state_q)
        S_IDLE: begin
          ceN_q <= 1'b1; // R3 R18
          cle_q <= 1'b0;
          ale_q <= 1'b0;
          ioOe_q <= 16'h0000;
          if (opValid && opReady) begin
            if (wpBad || colBad) begin
              opError_q <= 1'b1;
            end else if (opKind == `HFC_K_WAIT) begin
              cnt_q <= WB_CYC - 20'h00001;
              idx_q <= 2'h0;
              state_q <= S_WAIT; // R14
            end else begin
              kind_q <= opKind;
              data_q <= opData;
              idx_q <= 2'h0;
              ceN_q <= 1'b0; // R16
              cle_q <= isCmd; // R4
              ale_q <= (opKind == `HFC_K_ADDR); // R5
              cnt_q <= SETUP_CYC - 20'h00001;
              state_q <= S_SETUP;
              if (opKind == `HFC_K_RD) begin
                ioOe_q <= 16'h0000; // R2
              end else if (opKind == `HFC_K_WR) begin
                ioOut_q <= wordMode ? opData[15:0] :
                  {8'h00, opData[7:0]};
                ioOe_q <= wordMode ? `HFC_IO_ALL_OE :
                  `HFC_IO_LOW_OE; // R9
              end else begin
                ioOut_q <= {8'h00, (opKind == `HFC_K_ADDR) ?
                  addrByte(opData, 2'h0, wordMode) :
                  opData[7:0]}; // R8 R15
                ioOe_q <= `HFC_IO_LOW_OE; // R9
              end
            end
          end
        end
        S_SETUP: begin
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else if (kind_q == `HFC_K_RD) begin
            read_strobe_n_q <= 1'b0; // R2
            cnt_q <= RLO_CYC - 20'h00001;
            state_q <= S_RLO;
          end else begin
            weN_q <= 1'b0;
            cnt_q <= WLO_CYC - 20'h00001;
            state_q <= S_WLO;
          end
        end
        S_WLO: begin
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else begin
            weN_q <= 1'b1; // R6
            cnt_q <= WHI_CYC - 20'h00001;
            state_q <= S_WHI;
          end
        end
        S_WHI: begin
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else if (kind_q == `HFC_K_ADDR &&
              idx_q != `HFC_ADDR_CYCLES) begin
            idx_q <= idx_q + 2'h1;
            ioOut_q <= {8'h00, addrByte(data_q, idx_q + 2'h1,
              wordMode)}; // R15
            weN_q <= 1'b0;
            cnt_q <= WLO_CYC - 20'h00001;
            state_q <= S_WLO;
          end else begin
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            ioOe_q <= 16'h0000;
            state_q <= S_IDLE;
          end
        end
        S_RLO: begin
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else begin
            read_strobe_n_q <= 1'b1;
            bufData_q <= wordMode ? ioS2_q :
              {8'h00, ioS2_q[7:0]}; // R13
            bufPush_q <= 1'b1;
            cnt_q <= RHI_CYC - 20'h00001;
            state_q <= S_RHI;
          end
        end
        S_RHI: begin
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else begin
            state_q <= S_IDLE;
          end
        end
        S_WAIT: begin
          // Strobes stay high throughout (R17)
          if (cnt_q != 20'h00000 && idx_q == 2'h0) begin
            cnt_q <= cnt_q - 20'h00001;
          end else if (idx_q == 2'h0) begin
            idx_q <= 2'h1;
            cnt_q <= LIMIT_CYC;
          end else if (rbS2_q) begin
            state_q <= S_IDLE; // R1
          end else if (cnt_q == 20'h00000) begin
            opError_q <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* tb/hfc_flash_model.sv */
/*
  Behavioural x8 flash device facing the host pins.
  Assumes io is the resolved bus level; rbN models the pulled-up line.
*/
`timescale 1ns/1ns
module hfc_flash_model #(
  parameter int T_BUSY = 2000
) (
  // Host pins
  input wire ceN,
  input wire cle,
  input wire ale,
  input wire weN,
  input wire reN,
  input wire wpN,
  input wire [15:0] io,
  // Device pins
  output logic [15:0] ioDrv,
  output logic rbN
);
  logic [7:0] mem [int];
  logic [7:0] pbuf [int];
  logic [7:0] cmd = 8'h00;
  logic [27:0] adr = 28'h0;
  int col = 0;
  int nAddr = 0;
  int key;
  int q[$];
  bit busy = 0;
  assign rbN = !busy;
  initial ioDrv = 16'hA55A;

  task automatic go();
    busy = 1;
    fork
      begin
        #T_BUSY;
        busy = 0;
      end
    join_none
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge weN) begin
    if (!ceN && (!busy || cle && io[7:0] inside {8'hFF, 8'h70})) begin
      if (cle) begin
        cmd = io[7:0];
        if (cmd == 8'hFF) busy = 0;
        if (cmd == 8'h80) pbuf.delete();
        if (cmd == 8'h30) go();
        if (cmd == 8'h10 && wpN) begin
          foreach (pbuf[i]) mem[{adr[27:12], 12'h000} + i] = pbuf[i];
          go();
        end
        if (cmd == 8'hD0 && wpN) begin
          q.delete();
          foreach (mem[k]) if (k[27:18] == adr[27:18]) q.push_back(k);
          foreach (q[i]) mem.delete(q[i]);
          go();
        end
      end else if (ale) begin
        case (nAddr)
          0: adr[7:0] = io[7:0];
          1: adr[11:8] = io[3:0];
          2: adr[19:12] = io[7:0];
          default: adr[27:20] = io[7:0];
        endcase
        nAddr = (nAddr + 1) % 4;
        col = adr[11:0];
      end else begin
        pbuf[col] = io[7:0];
        col++;
      end
    end
  end

  always @(negedge reN) begin
    if (!ceN) begin
      key = {adr[27:12], 12'h000} + col;
      ioDrv[15:8] = ~ioDrv[15:8];
      ioDrv[7:0] = cmd == 8'h70 ? {wpN, !busy, 6'h00} :
        mem.exists(key) ? mem[key] : 8'hFF;
    end
  end

  always @(posedge reN) begin
    if (!ceN) begin
      ioDrv = ~ioDrv;
      col++;
    end
  end
endmodule

/* tb/hfc_host_assertions.sv */
/*
  Checker for the host pin sequencer, bound to every hfc_nand_host.
  Assumes the single ref_clk domain and active-low rst_b.
*/
`timescale 1ns/1ns
`include "hfc_map.vh"
module hfc_host_chk (
  // Clock, reset and request side
  input wire ref_clk,
  input wire rst_b,
  input wire clkEn,
  input wire opValid,
  input wire opReady,
  input wire [2:0] opKind,
  input wire [27:0] opData,
  input wire wordMode,
  input wire allowWrite,
  // Read port and status
  input wire rdValid,
  input wire rdReady,
  input wire [15:0] rdData,
  input wire opError_q,
  input wire devBusy,
  // Flash pins
  input wire ceN_q,
  input wire cle_q,
  input wire ale_q,
  input wire weN_q,
  input wire read_strobe_n_q,
  input wire wpN_q,
  input wire [15:0] ioOut_q,
  input wire [15:0] ioOe_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  wire take = opValid && opReady;
  wire isCmd = opKind == `HFC_K_CMD;
  wire modOp = isCmd && opData[7:0] inside
    {8'h80, 8'h85, 8'h8B, 8'h10, 8'h15, 8'h60, 8'hD0};

  ////////////////////////////////////////////////////////////////////////
  we_select_a: assert property (!weN_q |-> !ceN_q && read_strobe_n_q)
    else $error("write strobe low outside a selected cycle");
  latch_excl_a: assert property (cle_q |-> !ale_q)
    else $error("both latch enables high");
  re_nodrive_a: assert property (!read_strobe_n_q |-> ioOe_q == 16'h0000)
    else $error("host drives io while read strobe low");
  ce_quiet_a: assert property (ceN_q |-> weN_q && read_strobe_n_q
    && ioOe_q == 16'h0000) else $error("strobes active while deselected");
  high_byte_a: assert property (ioOe_q[15:8] != 8'h00 |-> wordMode
    && !cle_q && !ale_q) else $error("upper byte driven outside x16 data");
  busy_gate_a: assert property (take && devBusy |->
    opKind == `HFC_K_WAIT || isCmd && opData[7:0] inside {8'hFF, 8'h70})
    else $error("request taken while busy");
  wp_follow_a: assert property (clkEn |=> wpN_q == $past(allowWrite))
    else $error("write protect pin does not follow allowWrite");
  wp_refuse_a: assert property (take && modOp && !allowWrite |=>
    opError_q && ceN_q) else $error("modify opcode not refused");
  col_refuse_a: assert property (take && opKind == `HFC_K_ADDR &&
    !wordMode && opData[11:0] >= `HFC_PAGE_BYTES |=> opError_q)
    else $error("column beyond page not refused");
  cmd_walk_a: assert property (take && isCmd && !(modOp && !allowWrite)
    |=> !ceN_q && cle_q && weN_q && ioOut_q[7:0] == $past(opData[7:0])
    ##1 !weN_q ##1 weN_q) else $error("command cycle malformed");
  rd_hold_a: assert property (rdValid && !rdReady |=> rdValid &&
    $stable(rdData)) else $error("read word lost under stall");
endmodule

bind hfc_nand_host hfc_host_chk hfc_host_chk_i (.*);

/* tb/tb_hfc_nand_host.sv */
/*
  Self-checking bench: host sequencer against the flash model.
  Assumes design, model and checker are compiled before it.
*/
`timescale 1ns/1ns
`include "hfc_map.vh"
module tb_hfc_nand_host;
  logic ref_clk, rst_b, clkEn, opValid, rdReady, wordMode, allowWrite;
  logic [2:0] opKind;
  logic [27:0] opData;
  wire opReady, rdValid, opError_q, devBusy, ceN_q, cle_q, ale_q, weN_q;
  wire read_strobe_n_q, wpN_q, rbN;
  wire [15:0] rdData, ioOut_q, ioOe_q, ioDrv;
  wire [15:0] ioWire = (ioOe_q & ioOut_q) | (~ioOe_q & ioDrv);
  int n_mismatch = 0;
  int compares = 0;
  localparam logic [27:0] ROW = {10'h005, 6'h03, 12'h000};
  localparam logic [7:0] PAT [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
  localparam logic [7:0] MOD [7] = '{8'h80, 8'h85, 8'h8B, 8'h10, 8'h15,
    8'h60, 8'hD0};

  hfc_nand_host #(.BUSY_LIMIT(200)) hfc_nand_host_i (.ref_clk, .rst_b,
    .clkEn, .opValid, .opReady, .opKind, .opData, .wordMode, .allowWrite,
    .rdValid, .rdReady, .rdData, .opError_q, .devBusy, .ceN_q, .cle_q,
    .ale_q, .weN_q, .read_strobe_n_q, .wpN_q, .ioOut_q, .ioOe_q,
    .ioIn(ioWire), .rbN);
  hfc_flash_model hfc_flash_model_i (.ceN(ceN_q), .cle(cle_q), .ale(ale_q),
    .weN(weN_q), .reN(read_strobe_n_q), .wpN(wpN_q), .io(ioWire), .ioDrv,
    .rbN);

  ////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task report_and_stop();
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task req(input logic [2:0] k, input logic [27:0] d, input logic err);
    int n;
    n = 0;
    opValid <= 1'b1;
    opKind <= k;
    opData <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (opReady !== 1'b1 && n < 3000);
    if (opReady !== 1'b1) n_mismatch++;
    opValid <= 1'b0;
    @(posedge ref_clk);
    check(opError_q, err);
  endtask

  task pull(input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge ref_clk);
    rdReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rdValid !== 1'b1 && n < 50);
    if (rdValid !== 1'b1) n_mismatch++;
    rdReady <= 1'b0;
    check(rdData, exp);
  endtask

  task wait_ready();
    int n;
    n = 0;
    req(`HFC_K_WAIT, 28'h0, 0);
    do begin
      @(posedge ref_clk);
      n++;
    end while (opReady !== 1'b1 && n < 3000);
    if (opReady !== 1'b1) n_mismatch++;
    check(opError_q, 0);
    check(devBusy, 0);
  endtask

  task open_page();
    req(`HFC_K_CMD, 28'h00, 0);
    req(`HFC_K_ADDR, ROW, 0);
    req(`HFC_K_CMD, 28'h30, 0);
    check(hfc_flash_model_i.adr[27:12], ROW[27:12]);
    wait_ready();
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_prog_read();
    allowWrite <= 1'b1;
    req(`HFC_K_CMD, 28'h80, 0);
    req(`HFC_K_ADDR, ROW, 0);
    foreach (PAT[i]) req(`HFC_K_WR, 28'(PAT[i]), 0);
    req(`HFC_K_CMD, 28'h10, 0);
    repeat (8) @(posedge ref_clk);
    check(devBusy, 1);
    wait_ready();
    open_page();
    foreach (PAT[i]) begin
      req(`HFC_K_RD, 28'h0, 0);
      pull(PAT[i]);
    end
  endtask

  task t_stall();
    open_page();
    req(`HFC_K_RD, 28'h0, 0);
    req(`HFC_K_RD, 28'h0, 0);
    opValid <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check(opReady, 0);
    opValid <= 1'b0;
    pull(PAT[0]);
    pull(PAT[1]);
    req(`HFC_K_RD, 28'h0, 0);
    pull(PAT[2]);
  endtask

  task t_protect();
    allowWrite <= 1'b0;
    foreach (MOD[i]) req(`HFC_K_CMD, 28'(MOD[i]), 1);
    req(`HFC_K_ADDR, ROW | 28'h880, 1);
    clkEn <= 1'b0;
    wordMode <= 1'b1;
    repeat (5) @(posedge ref_clk);
    clkEn <= 1'b1;
    req(`HFC_K_WR, 28'hBEEF, 0);
    check(ioOut_q, 16'hBEEF);
    check(ioOe_q, 16'hFFFF);
    repeat (3) @(posedge ref_clk);
    wordMode <= 1'b0;
    allowWrite <= 1'b1;
    req(`HFC_K_CMD, 28'h60, 0);
    req(`HFC_K_ADDR, ROW, 0);
    req(`HFC_K_CMD, 28'hD0, 0);
    repeat (8) @(posedge ref_clk);
    opValid <= 1'b1;
    opData <= 28'h00;
    opKind <= `HFC_K_CMD;
    repeat (10) @(posedge ref_clk);
    check(opReady, 0);
    opValid <= 1'b0;
    @(posedge ref_clk);
    req(`HFC_K_CMD, 28'h70, 0);
    wait_ready();
    open_page();
    req(`HFC_K_RD, 28'h0, 0);
    pull(16'h00FF);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    #(40 * 20000);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    clkEn = 1'b1;
    opValid = 1'b0;
    rdReady = 1'b0;
    wordMode = 1'b0;
    allowWrite = 1'b0;
    opKind = 3'h0;
    opData = 28'h0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_prog_read();
    t_stall();
    t_protect();
    report_and_stop();
  end
endmodule
